// ===== hw/scpc_top.v
`timescale 1ns/1ns
`include "scpc_consts.vh"

// Contract
// R1: Clock-output fuse set drives system clock on clock pin, also during reset.
// R2: Clock pin carries the divided system clock whenever a division is applied.
// R3: Timer oscillator is usable only while an RC oscillator is the clock source.
// R4: Software sets external-clock select before applying an external timer clock.
// R5: Prescaler divides io, converter, cpu and program memory clocks by selected factor.
// R6: Changing the division produces no glitch on any derived clock.
// R7: No intermediate period during a change is shorter than old or new period.
// R8: New frequency takes effect after the old period ends, within bounded time.
// R9: Prescaler is a counter on the undivided clock, invisible to software.
// R10: Change-enable sets only when the same write zeroes all other bits.
// R11: Change-enable clears four cycles after set or when select is written.
// R12: Rewriting change-enable during its timeout neither restarts nor clears it.
// R13: Software writes change-enable, then within four cycles the new select value.
// R14: Software keeps interrupts disabled during the two-write change sequence.
// R15: Reset loads select 0000, or 0011 when the divide-by-eight fuse is set.
// R16: Select accepts any written value regardless of the divide-by-eight fuse.
// R17: Codes 0000 to 1000 divide by 1 to 256; higher codes are reserved.
// R18: Select sits in bits 3 to 0 and sets source to system clock ratio.
// R19: Reset loads factory calibration; software may overwrite it later.
// R20: Calibration bit 7 picks low range at 0, high range at 1.
// R21: Calibration bits 6 to 0 tune within the range, 0x00 lowest to 0x7F highest.
// R22: Software keeps calibration at or below 8.8MHz while writing nonvolatile memory.
// R23: Prescale register bits 6 to 4 read as zero and ignore writes.
module scpc_top #(
  parameter SEL_W = 4,
  parameter CNT_W = 8
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output reg  [31:0] hrdata,
  output wire        hresp,
  input  wire        clock_output_fuse,
  input  wire        divide_by_eight_fuse,
  input  wire [7:0]  factory_calibration,
  input  wire        rc_source_selected,
  output reg  [7:0]  calibration_value,
  output wire        calibration_range_bit,
  output wire [6:0]  calibration_fine_tune,
  output reg         sysclk_tick,
  output reg         sysclk_phase,
  output wire        cpu_clock_en,
  output wire        io_clock_en,
  output wire        converter_clock_en,
  output wire        program_memory_clock_en,
  output wire        sysclk_out_pin_o,
  output wire        sysclk_out_pin_oe,
  output reg         timer_osc_enable,
  output reg         timer_ext_clock_select
);

  reg  [1:0]       fuse_d8_s;
  reg  [1:0]       rc_src_s;
  reg  [7:0]       fcal_s0;
  reg  [7:0]       fcal_s1;
  reg  [1:0]       startup;
  reg              addr_valid;
  reg              addr_write;
  reg  [3:0]       addr_off;
  reg              prescale_change_enable;
  reg  [2:0]       pce_count;
  reg  [SEL_W-1:0] prescale_select;
  reg  [SEL_W-1:0] applied_select;
  reg  [CNT_W-1:0] div_cnt;
  reg              timer_osc_request;
  reg  [7:0]       next_cal;
  reg  [SEL_W-1:0] next_sel;
  reg              next_pce;
  reg  [2:0]       next_pce_count;
  reg              next_req;
  reg              next_ext;
  reg  [CNT_W-1:0] next_div_cnt;
  reg  [CNT_W-1:0] reload;
  reg  [CNT_W-1:0] half;
  reg  [SEL_W-1:0] next_applied;
  reg  [31:0]      next_rdata;
  wire             take;
  wire             wr_cal;
  wire             wr_pre;
  wire             wr_tosc;
  wire             in_startup;
  wire [7:0]       wbyte;

  assign hreadyout  = 1'b1;
  assign hresp      = `SCPC_HRESP_OKAY;
  assign take       = hsel & htrans[`SCPC_HTRANS_NONSEQ] & hready;
  assign in_startup = (startup != `SCPC_STARTUP_CYCLES);
  assign wbyte      = hwdata[7:0];
  assign wr_cal     = addr_valid & addr_write & (addr_off == `SCPC_ADDR_CAL);
  assign wr_pre     = addr_valid & addr_write & (addr_off == `SCPC_ADDR_PRESCALE);
  assign wr_tosc    = addr_valid & addr_write & (addr_off == `SCPC_ADDR_TIMER_OSC);

  assign calibration_range_bit   = calibration_value[`SCPC_CAL_RANGE_BIT]; // [R20]
  assign calibration_fine_tune   = calibration_value[6:0]; // [R21]

  // All four domains share one enable from the prescaler
  assign cpu_clock_en            = sysclk_tick; // [R5]
  assign io_clock_en             = sysclk_tick; // [R5]
  assign converter_clock_en      = sysclk_tick; // [R5]
  assign program_memory_clock_en = sysclk_tick; // [R5]

  // Raw fuse level so the pin is owned even while reset is asserted
  assign sysclk_out_pin_oe = clock_output_fuse; // [R1]
  // Undivided clock only when factor one is applied, else divided phase
  assign sysclk_out_pin_o  = (applied_select == `SCPC_SEL_RESET_DIV1) ? clk : sysclk_phase; // [R1] [R2]

  // Reserved codes clamp to the largest factor
  always @* begin
    reload = {CNT_W{1'b1}};
    if (next_applied <= `SCPC_SEL_MAX) begin
      reload = ({{(CNT_W-1){1'b0}}, 1'b1} << next_applied) - {{(CNT_W-1){1'b0}}, 1'b1}; // [R17]
    end
    half = (reload >> 1) + {{(CNT_W-1){1'b0}}, reload[0]};
  end

  always @* begin
    next_cal       = calibration_value;
    next_sel       = prescale_select;
    next_pce       = prescale_change_enable;
    next_pce_count = pce_count;
    next_req       = timer_osc_request;
    next_ext       = timer_ext_clock_select;
    if (in_startup) begin
      next_cal = fcal_s1; // [R19]
      next_sel = fuse_d8_s[1] ? `SCPC_SEL_RESET_DIV8 : `SCPC_SEL_RESET_DIV1; // [R15]
    end else begin
      if (prescale_change_enable) begin
        if (pce_count == `SCPC_PCE_TIMEOUT - 3'h1) begin
          next_pce = 1'b0; // [R11]
        end
        next_pce_count = pce_count + 3'h1;
      end
      if (wr_cal) begin
        next_cal = wbyte; // [R19]
      end
      if (wr_tosc) begin
        next_req = wbyte[`SCPC_TOSC_REQ_BIT];
        next_ext = wbyte[`SCPC_TOSC_EXT_BIT];
      end
      if (wr_pre) begin
        if (wbyte[`SCPC_PCE_BIT] && (wbyte[6:0] == 7'h00)) begin
          if (!prescale_change_enable) begin
            next_pce       = 1'b1; // [R10]
            next_pce_count = 3'h0;
          end
        end else if (!wbyte[`SCPC_PCE_BIT] && prescale_change_enable) begin
          next_sel = wbyte[`SCPC_SEL_MSB:0]; // [R16] [R18] [R23]
          next_pce = 1'b0; // [R11]
        end
      end
    end
  end

  // New select is adopted only at the end of the running period
  always @* begin
    next_applied = applied_select;
    next_div_cnt = div_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
    if (div_cnt == {CNT_W{1'b0}}) begin
      next_applied = prescale_select; // [R6] [R7] [R8]
      next_div_cnt = reload; // [R9]
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr[3:0])
      `SCPC_ADDR_CAL: begin
        next_rdata[7:0] = next_cal;
      end
      `SCPC_ADDR_PRESCALE: begin
        next_rdata[`SCPC_PCE_BIT] = next_pce;
        next_rdata[`SCPC_SEL_MSB:0] = next_sel; // [R23]
      end
      `SCPC_ADDR_TIMER_OSC: begin
        next_rdata[`SCPC_TOSC_REQ_BIT] = next_req;
        next_rdata[`SCPC_TOSC_EXT_BIT] = next_ext;
        next_rdata[`SCPC_TOSC_OK_BIT]  = rc_src_s[1];
      end
      `SCPC_ADDR_APPLIED: begin
        next_rdata[`SCPC_SEL_MSB:0] = applied_select;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_d8_s <= 2'h0;
      rc_src_s  <= 2'h0;
      fcal_s0   <= 8'h00;
      fcal_s1   <= 8'h00;
    end else if (clk_en) begin
      fuse_d8_s <= {fuse_d8_s[0], divide_by_eight_fuse};
      rc_src_s  <= {rc_src_s[0], rc_source_selected};
      fcal_s0   <= factory_calibration;
      fcal_s1   <= fcal_s0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startup                <= 2'h0;
      addr_valid             <= 1'b0;
      addr_write             <= 1'b0;
      addr_off               <= 4'h0;
      hrdata                 <= 32'h0000_0000;
      calibration_value      <= 8'h00;
      prescale_select        <= `SCPC_SEL_RESET_DIV1;
      prescale_change_enable <= 1'b0;
      pce_count              <= 3'h0;
      timer_osc_request      <= 1'b0;
      timer_ext_clock_select <= 1'b0;
      timer_osc_enable       <= 1'b0;
      applied_select         <= `SCPC_SEL_RESET_DIV1;
      div_cnt                <= {CNT_W{1'b0}};
      sysclk_tick            <= 1'b0;
      sysclk_phase           <= 1'b0;
    end else if (clk_en) begin
      if (in_startup) begin
        startup <= startup + 2'h1;
      end
      addr_valid <= take;
      if (take) begin
        addr_write <= hwrite;
        addr_off   <= haddr[3:0];
        hrdata     <= next_rdata;
      end
      calibration_value      <= next_cal;
      prescale_select        <= next_sel;
      prescale_change_enable <= next_pce;
      pce_count              <= next_pce_count;
      timer_osc_request      <= next_req;
      timer_ext_clock_select <= next_ext; // [R4]
      timer_osc_enable       <= next_req & rc_src_s[1]; // [R3]
      applied_select         <= next_applied;
      div_cnt                <= next_div_cnt; // [R9]
      sysclk_tick            <= (next_div_cnt == {CNT_W{1'b0}}); // [R5]
      sysclk_phase           <= (reload == {CNT_W{1'b0}}) | (next_div_cnt >= half); // [R6]
    end
  end

endmodule

// ===== hw/scpc_consts.vh
`ifndef SCPC_CONSTS_VH
`define SCPC_CONSTS_VH
`define SCPC_ADDR_CAL        4'h0
`define SCPC_ADDR_PRESCALE   4'h4
`define SCPC_ADDR_TIMER_OSC  4'h8
`define SCPC_ADDR_APPLIED    4'hC
`define SCPC_PCE_BIT         7
`define SCPC_SEL_MSB         3
`define SCPC_SEL_RESET_DIV1  4'h0
`define SCPC_SEL_RESET_DIV8  4'h3
`define SCPC_SEL_MAX         4'h8
`define SCPC_PCE_TIMEOUT     3'h4
`define SCPC_CAL_RANGE_BIT   7
`define SCPC_TOSC_REQ_BIT    0
`define SCPC_TOSC_EXT_BIT    1
`define SCPC_TOSC_OK_BIT     2
`define SCPC_STARTUP_CYCLES  2'h3
`define SCPC_HTRANS_NONSEQ   1
`define SCPC_HRESP_OKAY      1'b0
`endif

// ===== tb/scpc_props.sv
`timescale 1ns/1ns
module scpc_props (
  input wire       clk,
  input wire       rst_n,
  input wire       hreadyout,
  input wire       hresp,
  input wire       clock_output_fuse,
  input wire       rc_source_selected,
  input wire [7:0] calibration_value,
  input wire       calibration_range_bit,
  input wire [6:0] calibration_fine_tune,
  input wire       sysclk_tick,
  input wire       cpu_clock_en,
  input wire       io_clock_en,
  input wire       converter_clock_en,
  input wire       program_memory_clock_en,
  input wire       sysclk_out_pin_oe,
  input wire       timer_osc_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe; sysclk_out_pin_oe == clock_output_fuse; endproperty
  a_oe: assert property (p_oe) else $error("clock pin enable wrong");
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus answer not ready okay");
  property p_en1; cpu_clock_en == sysclk_tick && io_clock_en == sysclk_tick; endproperty
  a_en1: assert property (p_en1) else $error("cpu or io enable off tick");
  property p_en2;
    converter_clock_en == sysclk_tick && program_memory_clock_en == sysclk_tick;
  endproperty
  a_en2: assert property (p_en2) else $error("converter or memory enable off tick");
  property p_rng; calibration_range_bit == calibration_value[7]; endproperty
  a_rng: assert property (p_rng) else $error("range bit wrong");
  property p_fine; calibration_fine_tune == calibration_value[6:0]; endproperty
  a_fine: assert property (p_fine) else $error("fine tune wrong");
  property p_tosc;
    timer_osc_enable |-> $past(rc_source_selected, 2) || $past(rc_source_selected, 3);
  endproperty
  a_tosc: assert property (p_tosc) else $error("timer osc without rc source");
  property p_gap; !sysclk_tick |-> ##[1:255] sysclk_tick; endproperty
  a_gap: assert property (p_gap) else $error("tick gap too long");
endmodule
bind scpc_top scpc_props u_props (.clk, .rst_n, .hreadyout, .hresp, .clock_output_fuse,
  .rc_source_selected, .calibration_value, .calibration_range_bit, .calibration_fine_tune,
  .sysclk_tick, .cpu_clock_en, .io_clock_en, .converter_clock_en, .program_memory_clock_en,
  .sysclk_out_pin_oe, .timer_osc_enable);

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic        clk, rst_n, clk_en, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic        clock_output_fuse, divide_by_eight_fuse, rc_source_selected;
  logic [7:0]  factory_calibration;
  wire         hreadyout, hresp, sysclk_tick, sysclk_phase, sysclk_out_pin_o;
  wire         sysclk_out_pin_oe, timer_osc_enable, timer_ext_clock_select;
  wire         calibration_range_bit;
  wire  [31:0] hrdata;
  wire  [7:0]  calibration_value;
  int          failures, compares, cyc;
  scpc_top DUT (.clk, .rst_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .clock_output_fuse,
    .divide_by_eight_fuse, .factory_calibration, .rc_source_selected, .calibration_value,
    .calibration_range_bit, .calibration_fine_tune(), .sysclk_tick, .sysclk_phase,
    .cpu_clock_en(), .io_clock_en(), .converter_clock_en(), .program_memory_clock_en(),
    .sysclk_out_pin_o, .sysclk_out_pin_oe, .timer_osc_enable, .timer_ext_clock_select);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task print_verdict;
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task xfer(input [3:0] a, input w, input [7:0] d, output [31:0] q);
    @(posedge clk);
    hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {28'h0, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    logic [31:0] q;
    xfer(a, 1'h1, d, q);
  endtask
  task rd(input [3:0] a, input [7:0] e);
    logic [31:0] q;
    xfer(a, 1'h0, 8'h0, q);
    chk(q, {24'h0, e});
  endtask
  // Cycles between two consecutive system ticks
  task gap(input int f);
    int n;
    do @(posedge clk); while (sysclk_tick !== 1'h1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sysclk_tick !== 1'h1 && n < 600);
    chk(n, f);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      print_verdict;
    end
  end
  initial begin
    rst_n = 0; clk_en = 1; hsel = 0; hwrite = 0; haddr = 0; hwdata = 0; htrans = 0;
    clock_output_fuse = 1; divide_by_eight_fuse = 1; rc_source_selected = 1;
    factory_calibration = 8'hA5; failures = 0; compares = 0; cyc = 0;
    repeat (5) @(posedge clk);
    chk(sysclk_out_pin_oe, 32'h1);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    rd(4'h0, 8'hA5);
    rd(4'h4, 8'h03);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h80);
    chk(calibration_range_bit, 32'h1);
    wr(4'h4, 8'h81);
    rd(4'h4, 8'h03);
    wr(4'h4, 8'h80);
    rd(4'h4, 8'h83);
    rd(4'h4, 8'h03);
    wr(4'h4, 8'h80);
    wr(4'h4, 8'h80);
    rd(4'h4, 8'h03);
    wr(4'h4, 8'h80);
    wr(4'h4, 8'h75);
    rd(4'h4, 8'h05);
    wr(4'h4, 8'h06);
    rd(4'h4, 8'h05);
    for (int i = 0; i <= 9; i++) begin
      wr(4'h4, 8'h80);
      wr(4'h4, i[7:0]);
      rd(4'h4, i[7:0]);
      repeat (600) @(posedge clk);
      gap(i > 8 ? 256 : 1 << i);
      if (i > 0) chk(sysclk_out_pin_o, sysclk_phase);
    end
    wr(4'h8, 8'h01);
    repeat (6) @(posedge clk);
    chk(timer_osc_enable, 32'h1);
    rc_source_selected <= 1'h0;
    repeat (6) @(posedge clk);
    chk(timer_osc_enable, 32'h0);
    wr(4'h8, 8'h03);
    rd(4'h8, 8'h03);
    chk(timer_ext_clock_select, 32'h1);
    rd(4'h2, 8'h00);
    // Frozen enable: the write is never taken
    clk_en <= 1'h0;
    wr(4'h0, 8'h11);
    clk_en <= 1'h1;
    rd(4'h0, 8'h80);
    // Second reset with the divide-by-eight fuse clear
    divide_by_eight_fuse <= 1'h0;
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    rd(4'h4, 8'h00);
    rd(4'h0, 8'hA5);
    print_verdict;
  end
endmodule
